//--- design/bkpt_pkg.sv
package bkpt_pkg;
    // ==========================================
    // Debug control register numbers
    localparam logic [4:0] REG_PC_MASK = 5'h09;
    localparam logic [4:0] REG_TRIGGER = 5'h07;
    localparam logic [4:0] REG_EXT_TRIGGER = 5'h06;
    localparam logic [4:0] REG_PC_ADDR_PRI = 5'h08;
    localparam logic [4:0] REG_DATA_VALUE = 5'h0e;
    localparam logic [4:0] REG_DATA_MASK = 5'h0f;
    localparam logic [4:0] REG_PC_ADDR_ONE = 5'h18;
    localparam logic [4:0] REG_PC_ADDR_TWO = 5'h1a;
    localparam logic [4:0] REG_PC_ADDR_THREE = 5'h1b;
    localparam logic [4:0] REG_DATA_VALUE_2 = 5'h1e;
    localparam logic [4:0] REG_DATA_MASK_2 = 5'h1f;
    localparam logic [4:0] REG_STATUS = 5'h00;

    // ==========================================
    // Register fields; trigger fields at low-half positions (upper half adds HALF_SHIFT), response bits absolute, BIT_VALID for address registers
    localparam int HALF_SHIFT = 16;
    localparam int BIT_ENABLE = 13;
    localparam int BIT_EDLW = 12;
    localparam int BIT_EDWL = 11;
    localparam int BIT_EDWU = 10;
    localparam int BIT_EDLL = 9;
    localparam int BIT_EDLM = 8;
    localparam int BIT_EDUM = 7;
    localparam int BIT_EDUU = 6;
    localparam int BIT_INVERT = 5;
    localparam int BIT_EPC = 1;
    localparam int BIT_PCI = 0;
    localparam int BIT_RESP_HI = 31;
    localparam int BIT_RESP_LO = 30;
    localparam int BIT_VALID = 0;

    // ==========================================
    // Reset values and encodings
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [31:0] PC_ADDR_KEEP = 32'hffff_fffe;
    localparam logic [1:0] RESP_TRACE = 2'h0;
    localparam logic [1:0] RESP_HALT = 2'h1;
    localparam logic [1:0] RESP_INTR = 2'h2;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [3:0] STAT_IDLE = 4'h0;
    localparam logic [3:0] STAT_LEVEL1 = 4'h1;
    localparam logic [3:0] STAT_LEVEL2 = 4'h2;
    localparam logic [3:0] STAT_HIT1 = 4'h5;
    localparam logic [3:0] STAT_HIT2 = 4'h6;

    // Trigger sequencer states, Gray along arm, level one, level two
    typedef enum logic [1:0] {
        BKPT_ARMED = 2'b00,
        BKPT_FIRST = 2'b01,
        BKPT_FIRED = 2'b11
    } bkpt_seq_t;
endpackage : bkpt_pkg

//--- design/bkpt_match_if.sv
// Data comparator configuration and result between top and comparator
interface bkpt_match_if;
    logic [31:0] value;
    logic [31:0] mask;
    logic [6:0] lane_en;
    logic invert;
    logic hit;
    modport top (output value, output mask, output lane_en, output invert, input hit);
    modport cmp (input value, input mask, input lane_en, input invert, output hit);
endinterface : bkpt_match_if

//--- design/bkpt_data_cmp.sv
// Combinational data comparator for one value/mask pair
module bkpt_data_cmp
    import bkpt_pkg::*;
(
    // Local bus sample
    input wire logic [31:0] bus_data,
    input wire logic [1:0] bus_addr,
    input wire logic [1:0] bus_size,
    // Configuration and result
    bkpt_match_if.cmp m
);
    // ==========================================
    // Lane compare
    function automatic logic lane_eq(input logic [31:0] d, input logic [31:0] v,
                                     input logic [31:0] msk, input logic [31:0] sel);
        lane_eq = (((d ^ v) & ~msk & sel) == RESET_WORD);
    endfunction : lane_eq

    logic [31:0] sel;
    logic en_ok;
    logic eq;

    // Operand location by address and size; misaligned references still use these lanes
    always_comb begin
        sel = RESET_WORD;
        en_ok = 1'b0;
        case (bus_size)
            SIZE_BYTE: begin
                case (bus_addr)
                    2'h0: begin sel = 32'hff00_0000; en_ok = m.lane_en[0]; end
                    2'h1: begin sel = 32'h00ff_0000; en_ok = m.lane_en[1]; end
                    2'h2: begin sel = 32'h0000_ff00; en_ok = m.lane_en[2]; end
                    default: begin sel = 32'h0000_00ff; en_ok = m.lane_en[3]; end
                endcase
            end
            SIZE_WORD: begin
                if (!bus_addr[1]) begin
                    sel = 32'hffff_0000;
                    en_ok = m.lane_en[4];
                end else begin
                    sel = 32'h0000_ffff;
                    en_ok = m.lane_en[5];
                end
            end
            default: begin
                sel = 32'hffff_ffff;
                en_ok = m.lane_en[6];
            end
        endcase
        eq = lane_eq(bus_data, m.value, m.mask, sel);
    end

    // Invert turns equality into inequality on the selected lanes
    assign m.hit = en_ok & (eq ^ m.invert);
endmodule : bkpt_data_cmp

//--- design/bkpt_compare.sv
// Functional notes
// - Hold 32-bit data breakpoint values and compare with local data bus.
// - Paired data masks; set mask bit excludes that bit from compare.
// - Byte accesses select the lane from the two low address bits.
// - Word uses halves by address bit 1; longword uses all bits.
// - Four program-counter breakpoint registers compared with the program counter.
// - Program-counter breakpoint address lives in bits 31 to 1.
// - Three extra address registers compare only when valid bit 0 set.
// - Primary address register has no valid bit; bit 0 reads zero.
// - Program-counter mask applies only to the primary address register.
// - Mask bit zero includes address bit, one ignores it.
// - Program-counter mask is debug control register 0x09, core or host.
// - Trigger register upper half second level, lower half first level.
// - Trigger registers decide action when configured conditions occur.
// - A write to the trigger register (0x07), not the extended one, clears the breakpoint status field.
// - Response field: trace only, halt, debug interrupt, reserved.
// - Global enables in both halves of both trigger registers; all four clear disables all breakpoints.
// - Invert control reverses the sense of every data comparator.
module bkpt_compare
    import bkpt_pkg::*;
(
    // Clock, reset and enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Debug register read and write port (core instruction or host command)
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [4:0] reg_num,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // Processor local data bus
    input wire logic bus_xfer,
    input wire logic [1:0] bus_addr,
    input wire logic [1:0] bus_size,
    input wire logic [31:0] bus_data,
    // Executed instruction address
    input wire logic insn_exec,
    input wire logic [31:0] insn_pc,
    // Trigger results
    output logic trig_event,
    output logic [1:0] trigger_response_select,
    output logic halt_req,
    output logic debug_intr,
    output logic [3:0] breakpoint_status_field
);
    // ==========================================
    // State
    typedef struct packed {
        logic [31:0] data_break_value;
        logic [31:0] data_break_value_second;
        logic [31:0] data_break_mask;
        logic [31:0] data_break_mask_second;
        logic [31:0] pc_break_addr_primary;
        logic [31:0] pc_break_addr_one;
        logic [31:0] pc_break_addr_two;
        logic [31:0] pc_break_addr_three;
        logic [31:0] pc_break_mask;
        logic [31:0] trigger_definition_reg;
        logic [31:0] extended_trigger_definition;
        logic [3:0] stat;
        bkpt_seq_t seq;
        logic trig;
        logic halt;
        logic intr;
        logic [31:0] rdata;
    } bkpt_state_t;

    bkpt_state_t q;
    bkpt_state_t next_q;

    // ==========================================
    // Helpers
    // Lane enables from one half of a trigger register
    function automatic logic [6:0] lanes(input logic [15:0] h);
        lanes = {h[BIT_EDLW], h[BIT_EDWL], h[BIT_EDWU], h[BIT_EDLL], h[BIT_EDLM], h[BIT_EDUM], h[BIT_EDUU]};
    endfunction : lanes

    // Masked address equality; bit 0 never takes part
    function automatic logic pc_eq(input logic [31:0] pc, input logic [31:0] a, input logic [31:0] msk);
        pc_eq = (((pc ^ a) & ~msk & PC_ADDR_KEEP) == RESET_WORD);
    endfunction : pc_eq

    // ==========================================
    // Data comparators, one per value/mask pair
    bkpt_match_if m0 ();
    bkpt_match_if m1 ();

    logic [15:0] lvl1;
    logic [15:0] lvl2;
    logic lvl_sel;
    logic [15:0] act;
    logic any_en;

    // First level uses the low halves until the first level fires
    assign lvl1 = q.trigger_definition_reg[15:0] | q.extended_trigger_definition[15:0];
    assign lvl2 = q.trigger_definition_reg[31:16] | q.extended_trigger_definition[31:16];
    assign lvl_sel = (q.seq == BKPT_FIRST);
    assign act = lvl_sel ? lvl2 : lvl1;

    assign any_en = q.trigger_definition_reg[BIT_ENABLE] | q.trigger_definition_reg[BIT_ENABLE + HALF_SHIFT] |
                    q.extended_trigger_definition[BIT_ENABLE] |
                    q.extended_trigger_definition[BIT_ENABLE + HALF_SHIFT];

    assign m0.value = q.data_break_value;
    assign m0.mask = q.data_break_mask;
    assign m0.lane_en = lanes(act);
    assign m0.invert = act[BIT_INVERT];
    assign m1.value = q.data_break_value_second;
    assign m1.mask = q.data_break_mask_second;
    assign m1.lane_en = lanes(act);
    assign m1.invert = act[BIT_INVERT];

    bkpt_data_cmp u_cmp0 (
        .bus_data(bus_data),
        .bus_addr(bus_addr),
        .bus_size(bus_size),
        .m(m0.cmp)
    );
    bkpt_data_cmp u_cmp1 (
        .bus_data(bus_data),
        .bus_addr(bus_addr),
        .bus_size(bus_size),
        .m(m1.cmp)
    );

    // ==========================================
    // Match qualification
    logic data_hit;
    logic pc_hit;
    logic data_on;
    logic pc_on;
    logic level_hit;

    // Data match only counts on a real bus transfer
    assign data_on = (lanes(act) != 7'h00);
    assign data_hit = bus_xfer & (m0.hit | m1.hit);

    // Primary is masked; extras are exact and gated by valid
    assign pc_on = act[BIT_EPC];
    assign pc_hit = insn_exec & ((pc_eq(insn_pc, q.pc_break_addr_primary, q.pc_break_mask) ^ act[BIT_PCI]) |
                    (q.pc_break_addr_one[BIT_VALID] & pc_eq(insn_pc, q.pc_break_addr_one, RESET_WORD)) |
                    (q.pc_break_addr_two[BIT_VALID] & pc_eq(insn_pc, q.pc_break_addr_two, RESET_WORD)) |
                    (q.pc_break_addr_three[BIT_VALID] & pc_eq(insn_pc, q.pc_break_addr_three, RESET_WORD)));

    // Both enabled conditions must hold; at least one must be enabled
    assign level_hit = any_en & (data_on | pc_on) & (!data_on | data_hit) & (!pc_on | pc_hit);

    logic second_defined;
    assign second_defined = (lanes(lvl2) != 7'h00) | lvl2[BIT_EPC];

    // ==========================================
    // Next state: register writes, sequencer, responses
    always_comb begin
        next_q = q;
        next_q.trig = 1'b0;
        next_q.halt = 1'b0;
        next_q.intr = 1'b0;
        // Trigger sequencing
        if (!any_en) begin
            next_q.seq = BKPT_ARMED;
        end else begin
            case (q.seq)
                BKPT_ARMED: begin
                    if (level_hit && second_defined) begin
                        next_q.seq = BKPT_FIRST;
                        next_q.stat = STAT_LEVEL2;
                    end else if (level_hit) begin
                        next_q.seq = BKPT_FIRED;
                        next_q.stat = STAT_HIT1;
                    end
                end
                BKPT_FIRST: begin
                    if (level_hit) begin
                        next_q.seq = BKPT_FIRED;
                        next_q.stat = STAT_HIT2;
                    end
                end
                default: begin
                end
            endcase
        end
        // Completed trigger raises the selected response once
        if (next_q.seq == BKPT_FIRED && q.seq != BKPT_FIRED) begin
            next_q.trig = 1'b1;
            next_q.halt = (q.trigger_definition_reg[BIT_RESP_HI:BIT_RESP_LO] == RESP_HALT);
            next_q.intr = (q.trigger_definition_reg[BIT_RESP_HI:BIT_RESP_LO] == RESP_INTR);
        end
        // Register writes take effect after the compare of this cycle
        if (reg_wr) begin
            case (reg_num)
                REG_PC_MASK: next_q.pc_break_mask = reg_wdata;
                REG_TRIGGER: begin
                    next_q.trigger_definition_reg = reg_wdata;
                    next_q.stat = STAT_IDLE;
                    next_q.seq = BKPT_ARMED;
                    next_q.trig = 1'b0;
                    next_q.halt = 1'b0;
                    next_q.intr = 1'b0;
                end
                REG_EXT_TRIGGER: next_q.extended_trigger_definition = reg_wdata;
                REG_PC_ADDR_PRI: next_q.pc_break_addr_primary = reg_wdata & PC_ADDR_KEEP;
                REG_PC_ADDR_ONE: next_q.pc_break_addr_one = reg_wdata;
                REG_PC_ADDR_TWO: next_q.pc_break_addr_two = reg_wdata;
                REG_PC_ADDR_THREE: next_q.pc_break_addr_three = reg_wdata;
                REG_DATA_VALUE: next_q.data_break_value = reg_wdata;
                REG_DATA_MASK: next_q.data_break_mask = reg_wdata;
                REG_DATA_VALUE_2: next_q.data_break_value_second = reg_wdata;
                REG_DATA_MASK_2: next_q.data_break_mask_second = reg_wdata;
                default: begin
                end
            endcase
        end
        // Read data registered; unmapped numbers read zero
        if (reg_rd) begin
            case (reg_num)
                REG_PC_MASK: next_q.rdata = q.pc_break_mask;
                REG_TRIGGER: next_q.rdata = q.trigger_definition_reg;
                REG_EXT_TRIGGER: next_q.rdata = q.extended_trigger_definition;
                REG_PC_ADDR_PRI: next_q.rdata = q.pc_break_addr_primary & PC_ADDR_KEEP;
                REG_PC_ADDR_ONE: next_q.rdata = q.pc_break_addr_one;
                REG_PC_ADDR_TWO: next_q.rdata = q.pc_break_addr_two;
                REG_PC_ADDR_THREE: next_q.rdata = q.pc_break_addr_three;
                REG_DATA_VALUE: next_q.rdata = q.data_break_value;
                REG_DATA_MASK: next_q.rdata = q.data_break_mask;
                REG_DATA_VALUE_2: next_q.rdata = q.data_break_value_second;
                REG_DATA_MASK_2: next_q.rdata = q.data_break_mask_second;
                REG_STATUS: next_q.rdata = {28'h0000000, q.stat};
                default: next_q.rdata = RESET_WORD;
            endcase
        end
    end

    // State register; clock enable freezes everything
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (clk_en) begin
            q <= next_q;
        end
    end

    // ==========================================
    // Outputs
    assign reg_rdata = q.rdata;
    assign trig_event = q.trig;
    assign halt_req = q.halt;
    assign debug_intr = q.intr;
    assign trigger_response_select = q.trigger_definition_reg[BIT_RESP_HI:BIT_RESP_LO];
    assign breakpoint_status_field = q.stat;

    // ==========================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_tdr_write_clears: assert property (clk_en && reg_wr && reg_num == REG_TRIGGER |=> breakpoint_status_field == STAT_IDLE)
        else $error("Trigger write did not clear status");
    a_pri_bit0_zero: assert property (q.pc_break_addr_primary[0] == 1'b0)
        else $error("Primary address bit 0 set");
    a_pc_mask_write: assert property (clk_en && reg_wr && reg_num == REG_PC_MASK |=> q.pc_break_mask == $past(reg_wdata))
        else $error("Mask write lost");
    a_disabled_quiet: assert property (!any_en && !trig_event |=> !trig_event)
        else $error("Trigger while disabled");
    a_halt_resp: assert property (halt_req |-> trig_event && trigger_response_select == RESP_HALT)
        else $error("Halt without halt response");
    a_intr_resp: assert property (debug_intr |-> trig_event && trigger_response_select == RESP_INTR)
        else $error("Interrupt without interrupt response");
    a_trig_cause: assert property (trig_event |-> $past(level_hit) && $past(clk_en))
        else $error("Trigger without cause");
    a_data_xfer: assert property (data_hit |-> bus_xfer)
        else $error("Data hit outside transfer");
    a_extra_valid: assert property (insn_exec && !q.pc_break_addr_one[BIT_VALID] && !q.pc_break_addr_two[BIT_VALID] &&
        !q.pc_break_addr_three[BIT_VALID] && !pc_eq(insn_pc, q.pc_break_addr_primary, q.pc_break_mask) &&
        !act[BIT_PCI] |-> !pc_hit)
        else $error("Invalid extra register matched");
    a_mask_excl: assert property (bus_xfer && bus_size == SIZE_LONG && m0.lane_en[6] && !m0.invert &&
        (((bus_data ^ m0.value) & ~m0.mask) == RESET_WORD) |-> m0.hit)
        else $error("Masked compare missed");

    c_single: cover property (trig_event && breakpoint_status_field == STAT_HIT1);
    c_two_level: cover property (trig_event && breakpoint_status_field == STAT_HIT2);
    c_halt: cover property (halt_req);
    c_byte_hit: cover property (data_hit && bus_size == SIZE_BYTE);
endmodule : bkpt_compare

//--- bench/bkpt_core_model.sv
// Processor core side: one local bus transfer or one executed instruction per call
module bkpt_core_model (
    // Clock
    input wire logic mclk,
    // Local data bus toward the comparator
    output logic bus_xfer,
    output logic [1:0] bus_addr,
    output logic [1:0] bus_size,
    output logic [31:0] bus_data,
    // Executed instruction stream
    output logic insn_exec,
    output logic [31:0] insn_pc
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================
    // Idle state
    initial begin
        bus_xfer = 1'b0;
        bus_addr = 2'h0;
        bus_size = 2'h0;
        bus_data = 32'h0000_0000;
        insn_exec = 1'b0;
        insn_pc = 32'h0000_0000;
    end

    // ==========================================
    // Transfers
    // Qualifier stands one cycle; released address and data lines show the inverse so stale values never match
    // One idle edge first, so back-to-back calls never retoggle a strobe in one step
    task automatic xfer(input logic [1:0] a, input logic [1:0] s, input logic [31:0] d);
        @(posedge mclk);
        #1;
        bus_xfer = 1'b1;
        bus_addr = a;
        bus_size = s;
        bus_data = d;
        @(posedge mclk);
        #1;
        bus_xfer = 1'b0;
        bus_addr = ~a;
        bus_data = ~d;
    endtask : xfer

    // One executed instruction, then the address is scrambled
    task automatic insn(input logic [31:0] pc);
        @(posedge mclk);
        #1;
        insn_exec = 1'b1;
        insn_pc = pc;
        @(posedge mclk);
        #1;
        insn_exec = 1'b0;
        insn_pc = ~pc;
    endtask : insn
endmodule : bkpt_core_model

//--- bench/breakpoint_compare_logic_test.sv
`define CHECK(what, exp, got) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("[FAIL] %s expected %h seen %h", what, exp, got); \
        end \
    end

module breakpoint_compare_logic_test import bkpt_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk, rst_n, clk_en, reg_wr, reg_rd;
    logic [4:0] reg_num;
    logic [31:0] reg_wdata, reg_rdata, rdv, dv;
    logic bus_xfer, insn_exec, trig_event, halt_req, debug_intr;
    logic [1:0] bus_addr, bus_size, trigger_response_select;
    logic [31:0] bus_data, insn_pc;
    logic [3:0] breakpoint_status_field;
    int err_total = 0;
    int n_compared = 0;
    // Lane table: byte lanes by address, word halves, longword
    logic [31:0] lanes [7] = '{32'hff00_0000, 32'h00ff_0000, 32'h0000_ff00, 32'h0000_00ff,
        32'hffff_0000, 32'h0000_ffff, 32'hffff_ffff};
    logic [1:0] sizes [7] = '{SIZE_BYTE, SIZE_BYTE, SIZE_BYTE, SIZE_BYTE, SIZE_WORD, SIZE_WORD, SIZE_LONG};
    logic [1:0] addrs [7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3};
    int ens [7] = '{6, 7, 8, 9, 10, 11, 12};

    bkpt_compare uut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_num(reg_num), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .bus_xfer(bus_xfer),
        .bus_addr(bus_addr), .bus_size(bus_size), .bus_data(bus_data), .insn_exec(insn_exec),
        .insn_pc(insn_pc), .trig_event(trig_event), .trigger_response_select(trigger_response_select),
        .halt_req(halt_req), .debug_intr(debug_intr), .breakpoint_status_field(breakpoint_status_field));

    bkpt_core_model core (.mclk(mclk), .bus_xfer(bus_xfer), .bus_addr(bus_addr), .bus_size(bus_size),
        .bus_data(bus_data), .insn_exec(insn_exec), .insn_pc(insn_pc));

    // 200 MHz clock
    always #2.5 mclk = ~mclk;

    // ==========================================
    // Register access; an idle edge first keeps a strobe from dropping and rising in one step
    task automatic wr(input logic [4:0] n, input logic [31:0] d);
        @(posedge mclk);
        #1;
        reg_wr = 1'b1;
        reg_num = n;
        reg_wdata = d;
        @(posedge mclk);
        #1;
        reg_wr = 1'b0;
    endtask : wr

    // Read data is registered, so it is taken after the sampling edge
    task automatic rd(input logic [4:0] n, output logic [31:0] d);
        @(posedge mclk);
        #1;
        reg_rd = 1'b1;
        reg_num = n;
        @(posedge mclk);
        #1;
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd

    // Trigger outputs are one-cycle pulses, looked at right after the stimulus edge
    task automatic expect_trig(input string what, input logic hit, input logic [3:0] stat, input logic [1:0] resp);
        `CHECK({what, " event"}, hit, trig_event)
        `CHECK({what, " halt"}, hit & (resp == RESP_HALT), halt_req)
        `CHECK({what, " intr"}, hit & (resp == RESP_INTR), debug_intr)
        `CHECK({what, " status"}, stat, breakpoint_status_field)
    endtask : expect_trig

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    // ==========================================
    // Tests
    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_num = 5'h00;
        reg_wdata = 32'h0000_0000;
        repeat (16) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        `CHECK("reset rdata", 32'h0000_0000, reg_rdata)
        expect_trig("reset", 1'b0, STAT_IDLE, RESP_TRACE);
        $display("test reset done");
        wr(REG_PC_MASK, 32'ha5a5_0f0f);
        rd(REG_PC_MASK, rdv);
        `CHECK("pc mask", 32'ha5a5_0f0f, rdv)
        wr(REG_PC_ADDR_PRI, 32'h1234_5679);
        rd(REG_PC_ADDR_PRI, rdv);
        `CHECK("primary addr", 32'h1234_5678, rdv)
        wr(REG_PC_ADDR_ONE, 32'h8765_4321);
        rd(REG_PC_ADDR_ONE, rdv);
        `CHECK("addr one", 32'h8765_4321, rdv)
        rd(5'h03, rdv);
        `CHECK("unmapped", 32'h0000_0000, rdv)
        $display("test registers done");
        // Enables cleared before loading, as the logic has no interlock
        wr(REG_TRIGGER, RESET_WORD);
        wr(REG_PC_MASK, 32'h0000_00f0);
        wr(REG_PC_ADDR_PRI, 32'h0000_1000);
        wr(REG_PC_ADDR_ONE, 32'h0000_2000);
        wr(REG_PC_ADDR_TWO, 32'h0000_3001);
        wr(REG_PC_ADDR_THREE, 32'h0000_4001);
        for (int r = 0; r < 3; r++) begin
            wr(REG_TRIGGER, {r[1:0], 30'h0000_2002});
            `CHECK("resp select", r[1:0], trigger_response_select)
            core.insn(32'h0000_1100);
            expect_trig("pc unmasked bit", 1'b0, STAT_IDLE, r[1:0]);
            core.insn(32'h0000_1000 + 32'(r * 16));
            expect_trig("pc masked hit", 1'b1, STAT_HIT1, r[1:0]);
            core.insn(32'h0000_1000);
            expect_trig("pc after fire", 1'b0, STAT_HIT1, r[1:0]);
        end
        wr(REG_TRIGGER, 32'h0000_2002);
        `CHECK("status cleared", STAT_IDLE, breakpoint_status_field)
        core.insn(32'h0000_2000);
        expect_trig("invalid addr one", 1'b0, STAT_IDLE, RESP_TRACE);
        core.insn(32'h0000_3010);
        expect_trig("addr two unmasked", 1'b0, STAT_IDLE, RESP_TRACE);
        core.insn(32'h0000_3000);
        expect_trig("addr two hit", 1'b1, STAT_HIT1, RESP_TRACE);
        wr(REG_TRIGGER, 32'h0000_2002);
        clk_en = 1'b0;
        core.insn(32'h0000_4000);
        expect_trig("frozen", 1'b0, STAT_IDLE, RESP_TRACE);
        clk_en = 1'b1;
        core.insn(32'h0000_4000);
        expect_trig("addr three hit", 1'b1, STAT_HIT1, RESP_TRACE);
        wr(REG_TRIGGER, 32'h0000_0002);
        core.insn(32'h0000_4000);
        expect_trig("disabled", 1'b0, STAT_IDLE, RESP_TRACE);
        // Either register's enable is enough; halves of both registers combine
        wr(REG_EXT_TRIGGER, 32'h0000_2000);
        rd(REG_EXT_TRIGGER, rdv);
        `CHECK("ext trigger", 32'h0000_2000, rdv)
        core.insn(32'h0000_4000);
        expect_trig("ext enable", 1'b1, STAT_HIT1, RESP_TRACE);
        $display("test pc compare done");
        wr(REG_TRIGGER, RESET_WORD);
        wr(REG_EXT_TRIGGER, RESET_WORD);
        wr(REG_DATA_VALUE, 32'h5a5a_5a5a);
        wr(REG_DATA_MASK, RESET_WORD);
        // Only the selected lane carries the pattern, so a wrong lane cannot hit
        for (int i = 0; i < 7; i++) begin
            dv = (32'h5a5a_5a5a & lanes[i]) | (32'ha5a5_a5a5 & ~lanes[i]);
            wr(REG_TRIGGER, 32'h0000_2000 | (32'h1 << ens[i]));
            core.xfer(addrs[i], sizes[i], dv ^ (lanes[i] & ~(lanes[i] << 1)));
            expect_trig("lane flipped", 1'b0, STAT_IDLE, RESP_TRACE);
            core.xfer(addrs[i], sizes[i], dv);
            expect_trig("lane hit", 1'b1, STAT_HIT1, RESP_TRACE);
        end
        wr(REG_DATA_MASK, 32'h0000_0001);
        wr(REG_TRIGGER, 32'h0000_3000);
        core.xfer(2'h0, SIZE_LONG, 32'h5a5a_5a5b);
        expect_trig("masked bit", 1'b1, STAT_HIT1, RESP_TRACE);
        // Invert acts on both comparators, so the second one holds the same pattern
        wr(REG_DATA_VALUE_2, 32'h5a5a_5a5a);
        wr(REG_TRIGGER, 32'h0000_3020);
        core.xfer(2'h0, SIZE_LONG, 32'h5a5a_5a5a);
        expect_trig("invert equal", 1'b0, STAT_IDLE, RESP_TRACE);
        core.xfer(2'h0, SIZE_LONG, 32'h5a5a_4a5a);
        expect_trig("invert differ", 1'b1, STAT_HIT1, RESP_TRACE);
        $display("test data compare done");
        wr(REG_TRIGGER, RESET_WORD);
        wr(REG_PC_MASK, RESET_WORD);
        wr(REG_DATA_MASK, RESET_WORD);
        wr(REG_TRIGGER, 32'h2002_3000);
        core.insn(32'h0000_1000);
        expect_trig("second level early", 1'b0, STAT_IDLE, RESP_TRACE);
        core.xfer(2'h0, SIZE_LONG, 32'h5a5a_5a5a);
        expect_trig("first level", 1'b0, STAT_LEVEL2, RESP_TRACE);
        core.insn(32'h0000_1000);
        expect_trig("second level", 1'b1, STAT_HIT2, RESP_TRACE);
        rd(REG_STATUS, rdv);
        `CHECK("status reg", {28'h0000000, STAT_HIT2}, rdv)
        $display("test two level done");
        complete_run();
    end

    // Tests need under two hundred cycles; a hang is cut off well beyond that
    initial begin
        repeat (4000) @(posedge mclk);
        err_total++;
        complete_run();
    end
endmodule : breakpoint_compare_logic_test
